// *** pwg_pkg.sv ***
// Package with register map, field positions and reset values of the PWM block.
package pwg_pkg;

    localparam int NCH = 4;
    localparam int ADDR_W = 12;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_CLK = 8'h40;
    localparam logic [7:0] IDX_POL = 8'h41;
    localparam logic [7:0] IDX_EN = 8'h42;
    localparam logic [7:0] IDX_PRESC = 8'h43;
    localparam logic [7:0] IDX_SCAL0 = 8'h44;
    localparam logic [7:0] IDX_SCNT0 = 8'h45;
    localparam logic [7:0] IDX_SCAL1 = 8'h46;
    localparam logic [7:0] IDX_SCNT1 = 8'h47;
    localparam logic [7:0] IDX_CNT0 = 8'h48;
    localparam logic [7:0] IDX_PER0 = 8'h4c;
    localparam logic [7:0] IDX_DTY0 = 8'h50;
    localparam logic [7:0] IDX_CTRL = 8'h54;

    localparam logic [7:0] RST_CLK = 8'h00;
    localparam logic [7:0] RST_POL = 8'h00;
    localparam logic [3:0] RST_EN = 4'h0;
    localparam logic [7:0] RST_SCAL = 8'h00;
    localparam logic [7:0] RST_PER = 8'hff;
    localparam logic [7:0] RST_DTY = 8'hff;
    localparam logic RST_CENTER = 1'b0;

    localparam int BIT_JOIN_UPPER = 7;
    localparam int BIT_JOIN_LOWER = 6;
    localparam int PRESC_A_LSB = 3;
    localparam int PRESC_B_LSB = 0;
    localparam int SEL_LSB = 4;
    localparam int POL_LSB = 0;
    localparam int BIT_CENTER = 0;

    typedef enum logic {CH_UP, CH_DOWN} pwg_dir_t;

endpackage : pwg_pkg

// *** pwg_tick_if.sv ***
// Interface carrying the channel clock ticks and scaler readbacks.
`timescale 1ns/1ps
interface pwg_tick_if;
    logic tickA;
    logic tickB;
    logic tickS0;
    logic tickS1;
    logic [6:0] prescCount;
    logic [7:0] scaleCount0;
    logic [7:0] scaleCount1;

    modport gen (output tickA, tickB, tickS0, tickS1, prescCount, scaleCount0, scaleCount1);
    modport use_side (input tickA, tickB, tickS0, tickS1, prescCount, scaleCount0, scaleCount1);
endinterface : pwg_tick_if

// *** pwg_clkgen.sv ***
// Prescaler and the two scaled clocks, given as single-cycle ticks.
`timescale 1ns/1ps
module pwg_clkgen (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic anyEnable,
    input wire logic [2:0] prescA,
    input wire logic [2:0] prescB,
    input wire logic [7:0] scale0,
    input wire logic [7:0] scale1,
    input wire logic scaleWr0,
    input wire logic scaleWr1,
    pwg_tick_if.gen ticks
);
    import pwg_pkg::*;

    logic [6:0] presc, next_presc;
    logic [7:0] scnt0, next_scnt0, scnt1, next_scnt1;
    logic half0, next_half0, half1, next_half1;
    logic tickA, tickB;

    // Ticks are enables on the system clock, so no divided clock can glitch.
    function automatic logic divTick(input logic [6:0] cnt, input logic [2:0] sel);
        logic [6:0] mask;
        mask = 7'((8'h01 << sel) - 8'h01);
        return (cnt & mask) == mask;
    endfunction : divTick

    assign tickA = anyEnable & divTick(presc, prescA);
    assign tickB = anyEnable & divTick(presc, prescB);

    always_comb begin
        next_presc = anyEnable ? 7'(presc + 7'h01) : 7'h00;
        next_scnt0 = scnt0;
        next_half0 = half0;
        next_scnt1 = scnt1;
        next_half1 = half1;
        if (scaleWr0) begin
            next_scnt0 = scale0;
        end else if (tickA) begin
            next_scnt0 = (scnt0 == 8'h00) ? scale0 : 8'(scnt0 - 8'h01);
            next_half0 = (scnt0 == 8'h00) ? ~half0 : half0;
        end
        if (scaleWr1) begin
            next_scnt1 = scale1;
        end else if (tickB) begin
            next_scnt1 = (scnt1 == 8'h00) ? scale1 : 8'(scnt1 - 8'h01);
            next_half1 = (scnt1 == 8'h00) ? ~half1 : half1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            presc <= 7'h00;
            scnt0 <= 8'h00;
            scnt1 <= 8'h00;
            half0 <= 1'b0;
            half1 <= 1'b0;
        end else begin
            presc <= next_presc;
            scnt0 <= next_scnt0;
            scnt1 <= next_scnt1;
            half0 <= next_half0;
            half1 <= next_half1;
        end
    end

    assign ticks.tickA = tickA;
    assign ticks.tickB = tickB;
    assign ticks.tickS0 = tickA & (scnt0 == 8'h00) & half0;
    assign ticks.tickS1 = tickB & (scnt1 == 8'h00) & half1;
    assign ticks.prescCount = presc;
    assign ticks.scaleCount0 = scnt0;
    assign ticks.scaleCount1 = scnt1;

endmodule : pwg_clkgen

// *** pwg_chan.sv ***
// One waveform channel: counter, active period and duty latches, output level.
`timescale 1ns/1ps
module pwg_chan (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic tick,
    input wire logic enable,
    input wire logic center,
    input wire logic polarity,
    input wire logic clearCnt,
    input wire logic [15:0] perIn,
    input wire logic [15:0] dtyIn,
    output logic [15:0] count,
    output logic wave
);
    import pwg_pkg::*;

    logic [15:0] actPer, next_actPer, actDty, next_actDty, next_count;
    pwg_dir_t dir, next_dir;
    logic next_wave, roll, below;

    always_comb begin
        next_count = count;
        next_dir = dir;
        roll = 1'b0;
        if (clearCnt) begin
            next_count = 16'h0000;
            next_dir = CH_UP;
            roll = 1'b1;
        end else if (enable && tick) begin
            if (!center) begin
                if (count >= actPer) begin
                    next_count = 16'h0000;
                    roll = 1'b1;
                end else begin
                    next_count = 16'(count + 16'h0001);
                end
            end else if (dir == CH_UP) begin
                if (count >= actPer) begin
                    if (count == 16'h0000) begin
                        roll = 1'b1;
                    end else begin
                        next_dir = CH_DOWN;
                        next_count = 16'(count - 16'h0001);
                    end
                end else begin
                    next_count = 16'(count + 16'h0001);
                end
            end else begin
                if (count <= 16'h0001) begin
                    next_count = 16'h0000;
                    next_dir = CH_UP;
                    roll = 1'b1;
                end else begin
                    next_count = 16'(count - 16'h0001);
                end
            end
        end
        // Disabled latches follow the buffer so a stopped channel never mixes old and new.
        next_actPer = (!enable || roll) ? perIn : actPer;
        next_actDty = (!enable || roll) ? dtyIn : actDty;
        below = count < actDty;
        if (!enable) begin
            next_wave = 1'b0;
        end else if (center) begin
            next_wave = below;
        end else begin
            next_wave = polarity ? below : ~below;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count <= 16'h0000;
            dir <= CH_UP;
            actPer <= {8'h00, RST_PER};
            actDty <= {8'h00, RST_DTY};
            wave <= 1'b0;
        end else begin
            count <= next_count;
            dir <= next_dir;
            actPer <= next_actPer;
            actDty <= next_actDty;
            wave <= next_wave;
        end
    end

endmodule : pwg_chan

// *** pwg_top.sv ***
// Four-channel PWM generator with APB register access and port pin override.
//
// Contract
// - Four 8-bit channels, pairable into 16-bit.
// - Per-channel counter, period, duty; left or center, one setting for all channels.
// - Enabled channel applies new values at rollover.
// - Disabled channel writes reach latch directly.
// - Counter write resets and latches pending values.
// - Software reads each channel counter.
// - Enabled channel overrides general-purpose pin; the odd channel of a joined pair leaves its pin to the port.
// - Upper join: channel 2 high byte, pin 2.
// - Lower join: channel 0 high byte, pin 0.
// - Clock A is bus clock over 2^field.
// - Clock B uses same encoding, own field.
// - Channels 2,3 select clock B or S1.
// - Channels 0,1 select clock A or S0.
// - Clock select change may glitch one pulse.
// - Left-aligned polarity sets starting output level.
// - Duty counts low or high time by polarity; center mode ignores polarity and counts high time.
// - Scaled clock divides by value+1, then two.
// - Period is per+1 left, 2*per center.
// - Counter write zeroes; center counts up/down.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module pwg_top (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pwg_pkg::NCH-1:0] gpioOut,
    input wire logic [pwg_pkg::NCH-1:0] gpioDir,
    output logic [pwg_pkg::NCH-1:0] pinOut,
    output logic [pwg_pkg::NCH-1:0] pinOeN,
    output logic [pwg_pkg::NCH-1:0] pwmActive
);
    import pwg_pkg::*;

    // Software-visible configuration.
    logic [7:0] regClk, next_regClk;
    logic [7:0] regPol, next_regPol;
    logic [3:0] regEn, next_regEn;
    logic [7:0] regScal0, next_regScal0;
    logic [7:0] regScal1, next_regScal1;
    logic regCenter, next_regCenter;
    logic [7:0] perBuf [NCH];
    logic [7:0] next_perBuf [NCH];
    logic [7:0] dtyBuf [NCH];
    logic [7:0] next_dtyBuf [NCH];

    // Bus answer registers.
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;

    // Pin registers.
    logic [NCH-1:0] next_pinOut, next_pinOeN, next_pwmActive;

    // Decode.
    logic [7:0] idx;
    logic mapped, setup, wrTake;
    logic [1:0] sub;
    logic [NCH-1:0] cntClr;
    logic scaleWr0, scaleWr1;
    logic joinUpper, joinLower;

    // Channel wiring.
    logic [NCH-1:0] chTick, chEnable, chPol, chClear, chWave, chDrive;
    logic [15:0] chPer [NCH];
    logic [15:0] chDty [NCH];
    logic [15:0] chCount [NCH];
    logic [7:0] cntRead [NCH];

    pwg_tick_if ticks ();

    assign idx = paddr[9:2];
    assign sub = idx[1:0];
    assign setup = psel & ~penable;
    assign wrTake = psel & penable & pready & pwrite;
    assign joinUpper = regClk[BIT_JOIN_UPPER];
    assign joinLower = regClk[BIT_JOIN_LOWER];

    always_comb begin
        mapped = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00) &&
                 (idx >= IDX_CLK) && (idx <= IDX_CTRL);
    end

    pwg_clkgen u_clkgen (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .anyEnable(|regEn),
        .prescA(regClk[PRESC_A_LSB +: 3]),
        .prescB(regClk[PRESC_B_LSB +: 3]),
        .scale0(regScal0),
        .scale1(regScal1),
        .scaleWr0(scaleWr0),
        .scaleWr1(scaleWr1),
        .ticks(ticks)
    );

    // Channel routing; a joined pair runs in the even instance on 16-bit values.
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            logic paired;
            logic even;
            logic sel;
            logic useScaled;
            paired = (i < 2) ? joinLower : joinUpper;
            even = (i % 2) == 0;
            // The partner index stays inside the array for every channel.
            sel = (paired && even) ? regPol[SEL_LSB + (i ^ 1)] : regPol[SEL_LSB + i];
            useScaled = sel;
            // Switching the select mid-period may cut or stretch one pulse.
            if (i < 2) begin
                chTick[i] = useScaled ? ticks.tickS0 : ticks.tickA;
            end else begin
                chTick[i] = useScaled ? ticks.tickS1 : ticks.tickB;
            end
            chPol[i] = regPol[POL_LSB + i];
            if (paired && even) begin
                chPer[i] = {perBuf[i], perBuf[i ^ 1]};
                chDty[i] = {dtyBuf[i], dtyBuf[i ^ 1]};
                chClear[i] = cntClr[i] | cntClr[i ^ 1];
                chEnable[i] = regEn[i];
            end else begin
                chPer[i] = {8'h00, perBuf[i]};
                chDty[i] = {8'h00, dtyBuf[i]};
                chClear[i] = cntClr[i];
                chEnable[i] = regEn[i] & ~paired;
            end
            chDrive[i] = chEnable[i];
            if (paired && even) begin
                cntRead[i] = chCount[i][15:8];
            end else if (paired) begin
                cntRead[i] = chCount[i ^ 1][7:0];
            end else begin
                cntRead[i] = chCount[i][7:0];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            pwg_chan u_chan (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .tick(chTick[g]),
                .enable(chEnable[g]),
                .center(regCenter),
                .polarity(chPol[g]),
                .clearCnt(chClear[g]),
                .perIn(chPer[g]),
                .dtyIn(chDty[g]),
                .count(chCount[g]),
                .wave(chWave[g])
            );
        end
    endgenerate

    // Register writes take effect at the access edge with pready high.
    always_comb begin
        next_regClk = regClk;
        next_regPol = regPol;
        next_regEn = regEn;
        next_regScal0 = regScal0;
        next_regScal1 = regScal1;
        next_regCenter = regCenter;
        next_perBuf = perBuf;
        next_dtyBuf = dtyBuf;
        cntClr = '0;
        scaleWr0 = 1'b0;
        scaleWr1 = 1'b0;
        if (wrTake && mapped) begin
            case (idx)
                IDX_CLK: begin
                    next_regClk = pwdata[7:0];
                end
                IDX_POL: begin
                    next_regPol = pwdata[7:0];
                end
                IDX_EN: begin
                    next_regEn = pwdata[3:0];
                end
                IDX_SCAL0: begin
                    next_regScal0 = pwdata[7:0];
                    scaleWr0 = 1'b1;
                end
                IDX_SCAL1: begin
                    next_regScal1 = pwdata[7:0];
                    scaleWr1 = 1'b1;
                end
                IDX_CTRL: begin
                    next_regCenter = pwdata[BIT_CENTER];
                end
                default: begin
                    if (idx >= IDX_CNT0 && idx < IDX_PER0) begin
                        cntClr[sub] = 1'b1;
                    end else if (idx >= IDX_PER0 && idx < IDX_DTY0) begin
                        next_perBuf[sub] = pwdata[7:0];
                    end else if (idx >= IDX_DTY0 && idx < IDX_CTRL) begin
                        next_dtyBuf[sub] = pwdata[7:0];
                    end
                end
            endcase
        end
    end

    // Read data is captured in the setup cycle and shown in the access cycle.
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pready = setup;
        next_pslverr = setup & ~mapped;
        if (setup && mapped && !pwrite) begin
            case (idx)
                IDX_CLK: next_prdata[7:0] = regClk;
                IDX_POL: next_prdata[7:0] = regPol;
                IDX_EN: next_prdata[3:0] = regEn;
                IDX_PRESC: next_prdata[6:0] = ticks.prescCount;
                IDX_SCAL0: next_prdata[7:0] = regScal0;
                IDX_SCNT0: next_prdata[7:0] = ticks.scaleCount0;
                IDX_SCAL1: next_prdata[7:0] = regScal1;
                IDX_SCNT1: next_prdata[7:0] = ticks.scaleCount1;
                IDX_CTRL: next_prdata[BIT_CENTER] = regCenter;
                default: begin
                    if (idx >= IDX_CNT0 && idx < IDX_PER0) begin
                        next_prdata[7:0] = cntRead[sub];
                    end else if (idx >= IDX_PER0 && idx < IDX_DTY0) begin
                        next_prdata[7:0] = perBuf[sub];
                    end else if (idx >= IDX_DTY0 && idx < IDX_CTRL) begin
                        next_prdata[7:0] = dtyBuf[sub];
                    end
                end
            endcase
        end
    end

    // Pin mux: a running channel wins over the general-purpose port.
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            next_pinOut[i] = chDrive[i] ? chWave[i] : gpioOut[i];
            next_pinOeN[i] = ~(chDrive[i] | gpioDir[i]);
            next_pwmActive[i] = chDrive[i];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            regClk <= RST_CLK;
            regPol <= RST_POL;
            regEn <= RST_EN;
            regScal0 <= RST_SCAL;
            regScal1 <= RST_SCAL;
            regCenter <= RST_CENTER;
            for (int i = 0; i < NCH; i++) begin
                perBuf[i] <= RST_PER;
                dtyBuf[i] <= RST_DTY;
            end
        end else begin
            regClk <= next_regClk;
            regPol <= next_regPol;
            regEn <= next_regEn;
            regScal0 <= next_regScal0;
            regScal1 <= next_regScal1;
            regCenter <= next_regCenter;
            perBuf <= next_perBuf;
            dtyBuf <= next_dtyBuf;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pinOut <= '0;
            pinOeN <= '1;
            pwmActive <= '0;
        end else begin
            pinOut <= next_pinOut;
            pinOeN <= next_pinOeN;
            pwmActive <= next_pwmActive;
        end
    end

endmodule : pwg_top

// *** pwg_pin_load.sv ***
// Load model on the shared port pins, with pull-ups on every pin.
`timescale 1ns/1ps
module pwg_pin_load (
    input wire logic [pwg_pkg::NCH-1:0] pinOut,
    input wire logic [pwg_pkg::NCH-1:0] pinOeN,
    output logic [pwg_pkg::NCH-1:0] pad
);
    import pwg_pkg::*;
    // A released pin goes to its pull-up rather than keeping the last level.
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            pad[i] = pinOeN[i] ? 1'b1 : pinOut[i];
        end
    end
endmodule : pwg_pin_load

// *** pwg_top_props.sv ***
// Checker for the register bus answer and the pin ownership of the PWM block.
`timescale 1ns/1ps
module pwg_top_props (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwg_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [pwg_pkg::NCH-1:0] gpioOut,
    input wire logic [pwg_pkg::NCH-1:0] gpioDir,
    input wire logic [pwg_pkg::NCH-1:0] pinOut,
    input wire logic [pwg_pkg::NCH-1:0] pinOeN,
    input wire logic [pwg_pkg::NCH-1:0] pwmActive
);
    import pwg_pkg::*;
    logic okAddr;
    assign okAddr = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0
        && paddr[9:2] >= IDX_CLK && paddr[9:2] <= IDX_CTRL;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence setupS;
        psel && !penable;
    endsequence
    sequence answerS;
        psel && penable && pready;
    endsequence
    apb_answer_a: assert property (setupS |=> answerS)
        else $error("no answer after setup");
    ready_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("answer without setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("answer held too long");
    addr_refused_a: assert property (setupS ##0 !okAddr |=> pready && pslverr)
        else $error("bad address not refused");
    addr_taken_a: assert property (setupS ##0 okAddr |=> !pslverr)
        else $error("good address refused");
    refused_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    pin_owned_a: assert property ((pwmActive & pinOeN) == 4'h0)
        else $error("active channel not driving");
    gpio_dir_a: assert property ($past(nrst) && $past(nrst, 2) |->
        (pinOeN & $past(gpioDir)) == 4'h0)
        else $error("port direction ignored");
    gpio_value_a: assert property ($past(nrst) && $past(nrst, 2) |->
        ((pinOut ^ $past(gpioOut)) & ~pwmActive & ~pinOeN) == 4'h0)
        else $error("port value not passed");
endmodule : pwg_top_props

bind pwg_top pwg_top_props chk (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpioOut(gpioOut), .gpioDir(gpioDir), .pinOut(pinOut),
    .pinOeN(pinOeN), .pwmActive(pwmActive));

// *** tb_top.sv ***
// Self-checking bench for the PWM block, driven over the register bus.
`timescale 1ns/1ps
module tb_top;
    import pwg_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NCH-1:0] gpioOut = 4'h2;
    logic [NCH-1:0] gpioDir = 4'h2;
    logic [NCH-1:0] pinOut;
    logic [NCH-1:0] pinOeN;
    logic [NCH-1:0] pwmActive;
    logic [NCH-1:0] pad;
    logic [31:0] rd;
    logic err;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int highs;
    int rises;

    pwg_top uut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gpioOut(gpioOut), .gpioDir(gpioDir), .pinOut(pinOut),
        .pinOeN(pinOeN), .pwmActive(pwmActive));
    pwg_pin_load load (.pinOut(pinOut), .pinOeN(pinOeN), .pad(pad));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    // The whole run needs a few hundred cycles; a hang ends well past that.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            test_done();
        end
    end

    task test_done();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [ADDR_W-1:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ba

    // Holds the request until pready is seen high at a rising edge.
    task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // Only the bench timeout ends this wait.
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task w(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, ba(idx), {24'h0, d});
    endtask : w

    task rc(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, ba(idx), 32'h0);
        chk(rd, exp);
    endtask : rc

    task meas(input int ch, input int n);
        logic prev;
        highs = 0;
        rises = 0;
        // The pin lags a register change by the wave and pin flops, so let those settle.
        repeat (3) @(posedge clk_sys);
        prev = pad[ch];
        repeat (n) begin
            @(posedge clk_sys);
            highs += int'(pad[ch]);
            if (pad[ch] && !prev) rises++;
            prev = pad[ch];
        end
    endtask : meas

    task lvl(input int ch, input logic exp);
        repeat (6) @(posedge clk_sys);
        chk({31'h0, pad[ch]}, {31'h0, exp});
    endtask : lvl

    initial begin
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        rc(IDX_CLK, 32'h0);
        rc(IDX_PER0 + 8'h3, 32'hff);
        rc(IDX_DTY0, 32'hff);
        rc(IDX_EN, 32'h0);
        w(IDX_POL, 8'h5a);
        rc(IDX_POL, 32'h5a);
        w(IDX_CLK, 8'ha5);
        apb(1'b1, 12'h101, 32'h0);
        chk({31'h0, err}, 32'h1);
        rc(IDX_CLK, 32'ha5);
        apb(1'b0, ba(8'h60), 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, ba(IDX_PRESC), 32'h55);
        chk({31'h0, err}, 32'h0);
        $display("test registers done");
        // Clock S0 at its slowest keeps the counter still at zero for the whole test.
        w(IDX_CLK, 8'h38);
        w(IDX_SCAL0, 8'hff);
        w(IDX_POL, 8'h10);
        w(IDX_DTY0, 8'h00);
        w(IDX_PER0, 8'h10);
        w(IDX_CNT0, 8'h00);
        w(IDX_EN, 8'h01);
        lvl(0, 1'b1);
        chk({28'h0, pwmActive}, 32'h1);
        w(IDX_DTY0, 8'h05);
        lvl(0, 1'b1);
        w(IDX_CNT0, 8'h00);
        lvl(0, 1'b0);
        rc(IDX_CNT0, 32'h0);
        w(IDX_POL, 8'h11);
        lvl(0, 1'b1);
        w(IDX_EN, 8'h00);
        w(IDX_DTY0, 8'h00);
        lvl(0, 1'b1);
        w(IDX_EN, 8'h01);
        lvl(0, 1'b0);
        $display("test buffering done");
        w(IDX_CLK, 8'h00);
        w(IDX_POL, 8'h00);
        w(IDX_PER0, 8'h03);
        w(IDX_DTY0, 8'h01);
        w(IDX_CNT0, 8'h00);
        meas(0, 40);
        chk(highs, 30);
        chk(rises, 10);
        w(IDX_POL, 8'h01);
        meas(0, 40);
        chk(highs, 10);
        w(IDX_CTRL, 8'h01);
        meas(0, 60);
        chk(highs, 10);
        chk(rises, 10);
        w(IDX_CTRL, 8'h00);
        $display("test waveforms done");
        w(IDX_POL, 8'h00);
        w(IDX_CLK, 8'h40);
        w(IDX_PER0, 8'h00);
        w(IDX_PER0 + 8'h1, 8'h03);
        w(IDX_DTY0, 8'h00);
        w(IDX_DTY0 + 8'h1, 8'h01);
        w(IDX_EN, 8'h03);
        w(IDX_CNT0, 8'h00);
        meas(0, 40);
        chk(highs, 30);
        chk(rises, 10);
        chk({28'h0, pwmActive}, 32'h1);
        chk({31'h0, pad[1]}, 32'h1);
        w(IDX_CLK, 8'h80);
        w(IDX_EN, 8'h0c);
        repeat (3) @(posedge clk_sys);
        chk({28'h0, pwmActive}, 32'h4);
        $display("test pairing done");
        w(IDX_CLK, 8'h01);
        w(IDX_PER0 + 8'h2, 8'h01);
        w(IDX_DTY0 + 8'h2, 8'h01);
        w(IDX_EN, 8'h04);
        w(IDX_CNT0 + 8'h2, 8'h00);
        meas(2, 40);
        chk(highs, 20);
        chk(rises, 10);
        w(IDX_SCAL1, 8'h00);
        w(IDX_POL, 8'h40);
        w(IDX_CNT0 + 8'h2, 8'h00);
        meas(2, 40);
        chk(highs, 20);
        chk(rises, 5);
        $display("test clocks done");
        test_done();
    end
endmodule : tb_top
